// ---- core/rsq_pkg.sv ----
/*
  Package for the reset event sequencer: register offsets, reset
  values, cycle counts and the phase encoding.
  Assumes a 125 MHz system clock; the timing counts stand for
  16 MHz oscillator cycles and are converted here.
*/
package rsq_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_FUNC_STATUS = 8'h00;
  localparam logic [7:0] OFS_FUNC_DISABLE = 8'h04;
  localparam logic [7:0] OFS_FUNC_ALT = 8'h08;
  localparam logic [7:0] OFS_FUNC_SHORT = 8'h0C;
  localparam logic [7:0] OFS_FUNC_BIDIR = 8'h10;
  localparam logic [7:0] OFS_DEST_STATUS = 8'h14;
  localparam logic [7:0] OFS_DEST_DISABLE = 8'h18;
  localparam logic [7:0] OFS_DEST_ALT = 8'h1C;
  localparam logic [7:0] OFS_SEQ_STATE = 8'h20;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Clock rates in kHz
  localparam int CLK_KHZ = 125000;
  localparam int OSC_KHZ = 16000;

  // Least durations in oscillator cycles, rounded up to system cycles
  localparam int ZERO_OSC = 3;
  localparam int ONE_OSC = 350;
  localparam int TWO_OSC = 8;
  localparam int THREE_OSC = 40;
  localparam int BOOT_SAMPLES = 5;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] ZERO_CYC =
    CNT_W'((ZERO_OSC * CLK_KHZ + OSC_KHZ - 1) / OSC_KHZ);
  localparam logic [CNT_W-1:0] ONE_CYC =
    CNT_W'((ONE_OSC * CLK_KHZ + OSC_KHZ - 1) / OSC_KHZ);
  localparam logic [CNT_W-1:0] TWO_CYC =
    CNT_W'((TWO_OSC * CLK_KHZ + OSC_KHZ - 1) / OSC_KHZ);
  localparam logic [CNT_W-1:0] THREE_CYC =
    CNT_W'((THREE_OSC * CLK_KHZ + OSC_KHZ - 1) / OSC_KHZ);
  // Boot pin sample period, one oscillator cycle
  localparam logic [3:0] SAMPLE_DIV =
    4'((CLK_KHZ + OSC_KHZ / 2) / OSC_KHZ);

  typedef enum logic [4:0] {
    PH_ZERO = 5'b0_0001,
    PH_ONE = 5'b0_0010,
    PH_TWO = 5'b0_0100,
    PH_THREE = 5'b0_1000,
    PH_IDLE = 5'b1_0000
  } rsq_phase_t;

  // Alternate request outputs
  typedef struct packed {
    logic safeReq;
    logic irqReq;
  } rsq_alt_t;
endpackage

// ---- core/rsq_reset_event_sequencer.sv ----
/*
  Reset event sequencer: phases, external reset pin, functional and
  destructive sources, alternate requests, deep sleep entry and boot
  pin capture, with an AXI4-Lite register slave.
  Assumes pins arrive asynchronously; sources, power-on and flash
  status come from logic on clk_sys.
*/
// Function
// - External pin falling edge starts phase one
// - External flag set unless power-on active
// - Disable register writable once per power-on
// - External short bit starts at phase three
// - Drive pin low until phase three ends
// - Each source sets own flag, no priority
// - Each functional source individually disableable
// - Enabled source: phase one, short: three
// - Deep sleep accepted only when idle
// - Phase one counter frozen during deep sleep
// - Deep sleep resets domains, pin untouched
// - Flash-off run mode skips flash waits after deep sleep
// - Disable and alternate bits select event
// - Power-on always gives a reset sequence
// - Alternate request needs source low, flag cleared
// - Alternate requests not tied to sequencing
// - Masked destructive events discarded in phase zero, functional in one
// - Boot pins sampled before pin release
// - Captured one needs oldest three samples one
// - Internal pin drive forces fresh boot sampling
// - Phase one: sources done, 350 cycles
// - Phase two: flash done, 8 cycles
// - Phase three: flash done, 40 cycles
// - Idle releases system, awaits new events
`timescale 1ns/1ps
module rsq_reset_event_sequencer #(
  parameter int NF = 8,
  parameter int ND = 2
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic extResetIn,
  output logic extResetOut,
  output logic extResetOe,
  input wire logic bootPinLo,
  input wire logic bootPinHi,
  input wire logic powerOnReq,
  input wire logic powerOk,
  input wire logic [NF-1:1] funcSrc,
  input wire logic [ND-1:0] destSrc,
  input wire logic flashInitDone,
  input wire logic flashOffRunMode,
  input wire logic deepSleepReq,
  input wire logic deepSleepExit,
  output logic deepSleepAck,
  output rsq_pkg::rsq_phase_t phase,
  output logic sysReset,
  output logic flashReset,
  output logic domainReset,
  output logic [1:0] bootMode,
  output rsq_pkg::rsq_alt_t altReq
);
  logic [2:0] syncA, syncB;
  logic [1:0] oeHist;
  logic [4:0] histLo, histHi;
  logic [3:0] divCnt;
  logic [NF-1:0] funcPrev, fes, ferd, fear, fess, fbre, altF;
  logic [ND-1:0] destPrev, des, derd, dear, altD;
  logic extPrev, ferdLock, derdLock, sleepHold, flashOff, awHeld, wHeld;
  logic [rsq_pkg::CNT_W-1:0] cnt;
  logic [7:0] awAddr;
  logic [31:0] wData;
  rsq_pkg::rsq_phase_t next_phase;
  // Pin synchronisers; only syncB is read by logic
  always_ff @(posedge clk_sys) begin
    syncA <= {bootPinHi, bootPinLo, extResetIn};
    syncB <= syncA;
    extPrev <= syncB[0];
    oeHist <= {oeHist[0], extResetOe};
  end
  wire extNow = syncB[0];
  wire extRise = extNow & ~extPrev;
  wire inZero = (phase == rsq_pkg::PH_ZERO);
  wire inOne = (phase == rsq_pkg::PH_ONE);
  wire inThree = (phase == rsq_pkg::PH_THREE);
  wire inIdle = (phase == rsq_pkg::PH_IDLE);
  // Own drive is not an external event; bit 0 is the external reset. The
  // mask outlasts the drive by the two synchroniser stages, or our own
  // release would look like a fresh falling edge.
  wire [NF-1:0] funcLvl = {funcSrc, ~extNow & ~extResetOe & ~(|oeHist)};
  wire [NF-1:0] funcEvt = funcLvl & ~funcPrev;
  wire [ND-1:0] destEvt = destSrc & ~destPrev;
  wire [NF-1:0] funcRst = funcEvt & ~ferd;
  wire [ND-1:0] destRst = destEvt & ~derd;
  wire zeroGo = powerOnReq | (|destRst);
  wire longGo = |(funcRst & ~fess) & ~inZero;
  wire shortEvt = |(funcRst & fess) & ~inZero;
  wire shortGo = shortEvt & inIdle;
  wire sleepGo = inIdle & deepSleepReq & ~zeroGo & ~longGo & ~shortGo;
  wire pinSet = zeroGo | (|(funcRst & ~fbre)) | funcRst[0];
  wire flashOk = flashInitDone | flashOff;
  wire oneBusy = |(funcLvl & ~ferd & ~fess);
  wire zeroDone = (cnt >= rsq_pkg::ZERO_CYC - 1'b1);
  wire oneDone = (cnt >= rsq_pkg::ONE_CYC - 1'b1);
  wire twoDone = (cnt >= rsq_pkg::TWO_CYC - 1'b1);
  wire threeDone = (cnt >= rsq_pkg::THREE_CYC - 1'b1);
  always_comb begin
    next_phase = phase;
    case (phase)
      rsq_pkg::PH_ZERO: begin
        if (powerOk && zeroDone && !(|(destSrc & ~derd))) begin
          next_phase = rsq_pkg::PH_ONE;
        end
      end
      rsq_pkg::PH_ONE: begin
        if (!sleepHold && oneDone && !oneBusy) begin
          next_phase = rsq_pkg::PH_TWO;
        end
      end
      rsq_pkg::PH_TWO: begin
        if (flashOk && twoDone) begin
          next_phase = rsq_pkg::PH_THREE;
        end
      end
      rsq_pkg::PH_THREE: begin
        if (flashOk && threeDone) begin
          next_phase = rsq_pkg::PH_IDLE;
        end
      end
      rsq_pkg::PH_IDLE: begin
        if (sleepGo) begin
          next_phase = rsq_pkg::PH_ONE;
        end
      end
      default: begin
        next_phase = rsq_pkg::PH_ZERO;
      end
    endcase
    if (zeroGo) begin
      next_phase = rsq_pkg::PH_ZERO;
    end else if (longGo) begin
      next_phase = rsq_pkg::PH_ONE;
    end else if (shortGo) begin
      next_phase = rsq_pkg::PH_THREE;
    end
  end
  // Restart the count on entry and on each qualifying event
  wire cntClr = (next_phase != phase) | (inZero & zeroGo) | (inOne & longGo)
    | (inThree & shortEvt);
  wire cntSat = (cnt == {rsq_pkg::CNT_W{1'b1}});
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      phase <= rsq_pkg::PH_ZERO;
      cnt <= '0;
      sleepHold <= 1'b0;
      flashOff <= 1'b0;
      extResetOe <= 1'b1;
      deepSleepAck <= 1'b0;
    end else begin
      phase <= next_phase;
      if (cntClr) begin
        cnt <= '0;
      end else if (!cntSat && !sleepHold) begin
        cnt <= cnt + 1'b1;
      end
      if (zeroGo || longGo || shortGo) begin
        sleepHold <= 1'b0;
      end else if (sleepGo) begin
        sleepHold <= 1'b1;
      end else if (deepSleepExit) begin
        sleepHold <= 1'b0;
      end
      if (zeroGo || longGo) begin
        flashOff <= 1'b0;
      end else if (sleepGo) begin
        flashOff <= flashOffRunMode;
      end
      // Deep sleep entry never touches the pin
      if (pinSet) begin
        extResetOe <= 1'b1;
      end else if (inThree && next_phase == rsq_pkg::PH_IDLE) begin
        extResetOe <= 1'b0;
      end
      deepSleepAck <= sleepGo;
    end
  end
  // Registered decodes of the next phase and the deep sleep state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sysReset <= 1'b1;
      flashReset <= 1'b1;
      domainReset <= 1'b0;
      extResetOut <= 1'b0;
    end else begin
      sysReset <= (next_phase != rsq_pkg::PH_IDLE);
      flashReset <= (next_phase == rsq_pkg::PH_ZERO) | (next_phase == rsq_pkg::PH_ONE)
        | (flashOff & ~zeroGo & ~longGo) | (sleepGo & flashOffRunMode);
      domainReset <= (sleepHold | sleepGo) & ~zeroGo & ~longGo & ~shortGo;
      extResetOut <= 1'b0;
    end
  end
  // Boot pin history on an oscillator-rate tick
  wire sampleTick = (divCnt == rsq_pkg::SAMPLE_DIV - 1'b1);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      divCnt <= '0;
      histLo <= '0;
      histHi <= '0;
      bootMode <= 2'b00;
    end else begin
      divCnt <= sampleTick ? 4'h0 : divCnt + 1'b1;
      if (sampleTick) begin
        histLo <= {histLo[3:0], syncB[1]};
        histHi <= {histHi[3:0], syncB[2]};
      end
      // Every pin release recaptures, including after our own drive
      if (extRise) begin
        bootMode <= {&histHi[4:2], &histLo[4:2]};
      end
    end
  end
  // Flags set by the source level and held until cleared, blocked during power-on
  wire [NF-1:0] fesSet = powerOnReq ? '0 : funcLvl;
  wire [ND-1:0] desSet = powerOnReq ? '0 : destSrc;
  // Alternate request hold: set by a masked source, held until both the
  // source and the flag are gone. Masked functional arrivals in phase one and
  // masked destructive arrivals in phase zero are discarded.
  wire [NF-1:0] next_altF = ferd & ((funcLvl & ~{NF{inOne}})
    | (altF & (funcLvl | fes)));
  wire [ND-1:0] next_altD = derd & ((destSrc & ~{ND{inZero}})
    | (altD & (destSrc | des)));
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      funcPrev <= '0;
      destPrev <= '0;
      altF <= '0;
      altD <= '0;
      altReq <= '0;
    end else begin
      funcPrev <= funcLvl;
      destPrev <= destSrc;
      altF <= next_altF;
      altD <= next_altD;
      // Raised from the held terms alone, which drop masked arrivals in phase one (functional) and zero (destructive)
      altReq.safeReq <= |(next_altF & ~fear) | (|(next_altD & ~dear));
      altReq.irqReq <= |(next_altF & fear) | (|(next_altD & dear));
    end
  end
  // AXI4-Lite write path: address and data taken in either order
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
  wire wrLane = s_axi_wstrb[0];
  wire [31:0] wClr = wrLane ? wData : 32'h0000_0000;
  wire wrFes = doWrite & (awAddr == rsq_pkg::OFS_FUNC_STATUS);
  wire wrFerd = doWrite & (awAddr == rsq_pkg::OFS_FUNC_DISABLE) & wrLane;
  wire wrFear = doWrite & (awAddr == rsq_pkg::OFS_FUNC_ALT) & wrLane;
  wire wrFess = doWrite & (awAddr == rsq_pkg::OFS_FUNC_SHORT) & wrLane;
  wire wrFbre = doWrite & (awAddr == rsq_pkg::OFS_FUNC_BIDIR) & wrLane;
  wire wrDes = doWrite & (awAddr == rsq_pkg::OFS_DEST_STATUS);
  wire wrDerd = doWrite & (awAddr == rsq_pkg::OFS_DEST_DISABLE) & wrLane;
  wire wrDear = doWrite & (awAddr == rsq_pkg::OFS_DEST_ALT) & wrLane;
  wire wrHit = (awAddr[7:2] <= rsq_pkg::OFS_SEQ_STATE[7:2]) & (awAddr[1:0] == 2'b00);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rsq_pkg::RESP_OKAY;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= rsq_pkg::REG_RESET;
    end else begin
      if (awTake) begin
        awAddr <= s_axi_awaddr[7:0];
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (wTake) begin
        wData <= s_axi_wdata;
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? rsq_pkg::RESP_OKAY : rsq_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // Register file; status bits are write-one-to-clear and a new set wins
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fes <= '0;
      des <= '0;
      ferd <= '0;
      derd <= '0;
      fear <= '0;
      dear <= '0;
      fess <= '0;
      fbre <= '0;
      ferdLock <= 1'b0;
      derdLock <= 1'b0;
    end else begin
      fes <= (fes & ~(wrFes ? wClr[NF-1:0] : '0)) | fesSet;
      des <= (des & ~(wrDes ? wClr[ND-1:0] : '0)) | desSet;
      // Disable registers lock after one write until the next power-on
      if (powerOnReq) begin
        ferdLock <= 1'b0;
        derdLock <= 1'b0;
      end else begin
        if (wrFerd && !ferdLock) begin
          ferd <= wData[NF-1:0];
          ferdLock <= 1'b1;
        end
        if (wrDerd && !derdLock) begin
          derd <= wData[ND-1:0];
          derdLock <= 1'b1;
        end
      end
      if (wrFear) begin
        fear <= wData[NF-1:0];
      end
      if (wrDear) begin
        dear <= wData[ND-1:0];
      end
      if (wrFess) begin
        fess <= wData[NF-1:0];
      end
      if (wrFbre) begin
        fbre <= wData[NF-1:0];
      end
    end
  end
  // Read path
  wire arTake = s_axi_arvalid & s_axi_arready;
  wire [7:0] rAddr = s_axi_araddr[7:0];
  wire [31:0] seqState = {21'h0, bootMode, extResetOe, sleepHold,
    ferdLock, derdLock, phase};
  wire rdHit = (rAddr[7:2] <= rsq_pkg::OFS_SEQ_STATE[7:2]) & (rAddr[1:0] == 2'b00);
  wire [31:0] rdMux =
    (rAddr == rsq_pkg::OFS_FUNC_STATUS) ? 32'(fes) :
    (rAddr == rsq_pkg::OFS_FUNC_DISABLE) ? 32'(ferd) :
    (rAddr == rsq_pkg::OFS_FUNC_ALT) ? 32'(fear) :
    (rAddr == rsq_pkg::OFS_FUNC_SHORT) ? 32'(fess) :
    (rAddr == rsq_pkg::OFS_FUNC_BIDIR) ? 32'(fbre) :
    (rAddr == rsq_pkg::OFS_DEST_STATUS) ? 32'(des) :
    (rAddr == rsq_pkg::OFS_DEST_DISABLE) ? 32'(derd) :
    (rAddr == rsq_pkg::OFS_DEST_ALT) ? 32'(dear) :
    (rAddr == rsq_pkg::OFS_SEQ_STATE) ? seqState : 32'h0000_0000;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= rsq_pkg::REG_RESET;
      s_axi_rresp <= rsq_pkg::RESP_OKAY;
    end else begin
      if (arTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? rsq_pkg::RESP_OKAY : rsq_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// ---- sim/rsq_seq_sva.sv ----
/*
  Port checker for the reset event sequencer: phase dwell times,
  pin drive, deep sleep handling and power-on entry.
  Assumes the single clk_sys domain and the top module's port names.
*/
`timescale 1ns/1ps
module rsq_seq_sva (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic extResetOe,
  input wire logic powerOnReq,
  input wire logic deepSleepExit,
  input wire logic deepSleepAck,
  input wire rsq_pkg::rsq_phase_t phase,
  input wire logic sysReset,
  input wire logic domainReset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  rsq_pkg::rsq_phase_t prevPhase;
  logic [11:0] dwell;
  logic asleep;
  // Dwell counts consecutive cycles of the phase just left, so it is
  // never below the count since the last restarting event
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prevPhase <= rsq_pkg::PH_ZERO;
      dwell <= 12'h000;
      asleep <= 1'b0;
    end else begin
      prevPhase <= phase;
      dwell <= (phase != prevPhase) ? 12'h001 : dwell + 12'(dwell != 12'hFFF);
      asleep <= deepSleepAck | (asleep & !deepSleepExit);
    end
  end
  sequence s_left(rsq_pkg::rsq_phase_t a, rsq_pkg::rsq_phase_t b);
    prevPhase == a && phase == b;
  endsequence
  property p_idle_free; phase == rsq_pkg::PH_IDLE |-> !sysReset; endproperty
  a_idle_free: assert property (p_idle_free)
    else $error("system reset held while idle");
  property p_pin_release; $fell(extResetOe) |-> s_left(rsq_pkg::PH_THREE, rsq_pkg::PH_IDLE);
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("pin released outside end of phase three");
  property p_por; $rose(powerOnReq) |=> phase == rsq_pkg::PH_ZERO; endproperty
  a_por: assert property (p_por)
    else $error("power-on did not restart phase zero");
  property p_one_exit; s_left(rsq_pkg::PH_ONE, rsq_pkg::PH_TWO) |-> dwell >= rsq_pkg::ONE_CYC;
  endproperty
  a_one_exit: assert property (p_one_exit)
    else $error("phase one too short");
  property p_two_exit;
    s_left(rsq_pkg::PH_TWO, rsq_pkg::PH_THREE) |-> dwell >= rsq_pkg::TWO_CYC;
  endproperty
  a_two_exit: assert property (p_two_exit)
    else $error("phase two too short");
  property p_three_exit;
    s_left(rsq_pkg::PH_THREE, rsq_pkg::PH_IDLE) |-> dwell >= rsq_pkg::THREE_CYC;
  endproperty
  a_three_exit: assert property (p_three_exit)
    else $error("phase three too short");
  property p_sleep_pin; domainReset |-> !extResetOe; endproperty
  a_sleep_pin: assert property (p_sleep_pin)
    else $error("pin driven during deep sleep");
  property p_sleep_hold; asleep |-> phase inside {rsq_pkg::PH_IDLE, rsq_pkg::PH_ONE}; endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("phase one left before deep sleep exit");
  property p_sleep_ack;
    deepSleepAck |-> prevPhase == rsq_pkg::PH_IDLE || phase == rsq_pkg::PH_IDLE;
  endproperty
  a_sleep_ack: assert property (p_sleep_ack)
    else $error("deep sleep accepted outside idle");
endmodule
bind rsq_reset_event_sequencer rsq_seq_sva rsq_seq_sva_i (.clk_sys(clk_sys), .rst_b(rst_b),
  .extResetOe(extResetOe), .powerOnReq(powerOnReq), .deepSleepExit(deepSleepExit),
  .deepSleepAck(deepSleepAck), .phase(phase), .sysReset(sysReset), .domainReset(domainReset));

// ---- sim/rsq_far_side.sv ----
/*
  Far-side model: reset line with pull-up, boot pins and the mode
  controller's wakeup after deep sleep.
  Assumes the bench commands pulls and boot values between sequences.
*/
`timescale 1ns/1ps
module rsq_far_side (
  input wire logic clk_sys,
  input wire logic extResetOe,
  input wire logic pullLow,
  input wire logic [1:0] bootVal,
  input wire logic deepSleepAck,
  output logic extResetIn,
  output logic bootPinLo,
  output logic bootPinHi,
  output logic deepSleepExit
);
  logic [7:0] sleepCnt;
  logic asleep;
  // Pulled up: low only while either party drives it
  assign extResetIn = !(extResetOe || pullLow);
  // Bench sets the value 60 cycles before any pull, above the 40 cycles of five periods
  assign bootPinLo = bootVal[0];
  assign bootPinHi = bootVal[1];
  initial begin
    asleep = 1'b0;
    sleepCnt = 8'h00;
    deepSleepExit = 1'b0;
  end
  always @(posedge clk_sys) begin
    asleep <= deepSleepAck | (asleep & !deepSleepExit);
    sleepCnt <= asleep ? sleepCnt + 8'h01 : 8'h00;
    deepSleepExit <= asleep && sleepCnt == 8'hC8;
  end
endmodule

// ---- sim/rsq_reset_event_sequencer_tb.sv ----
/*
  Self-checking bench for the reset event sequencer: AXI4-Lite master,
  far-side model; the checker is attached by bind.
  Assumes a 125 MHz clock; the far side ends deep sleep on its own.
*/
`timescale 1ns/1ps
module rsq_reset_event_sequencer_tb;
  typedef struct packed {logic [7:0] ofs; logic [31:0] data; logic [1:0] resp;} rsq_row_t;
  rsq_row_t rows [0:10] = '{'{8'h00, 32'h0, 2'h0}, '{8'h04, 32'h0, 2'h0},
    '{8'h08, 32'h0, 2'h0}, '{8'h0C, 32'h0, 2'h0}, '{8'h10, 32'h0, 2'h0},
    '{8'h14, 32'h0, 2'h0}, '{8'h18, 32'h0, 2'h0}, '{8'h1C, 32'h0, 2'h0},
    '{8'h20, 32'h0000_0101, 2'h0}, '{8'h24, 32'h0, 2'h2}, '{8'h02, 32'h0, 2'h2}};
  logic clk_sys, rst_b, awvalid, wvalid, bready, arvalid, rready, pullLow;
  logic [31:0] awaddr, wdata, araddr;
  logic [3:0] wstrb;
  logic [1:0] bootVal, destSrc;
  logic [7:1] funcSrc;
  logic powerOnReq, powerOk, flashInitDone, flashOffRunMode, deepSleepReq;
  logic awready, wready, bvalid, arready, rvalid, extResetIn, extResetOe, bootPinLo, bootPinHi;
  logic deepSleepExit, deepSleepAck, sysReset, flashReset, domainReset, extResetOut;
  logic [1:0] bresp, rresp, bootMode;
  logic [31:0] rdata;
  rsq_pkg::rsq_phase_t phase;
  rsq_pkg::rsq_alt_t altReq;
  int n_mismatch = 0;
  int comparisons = 0;
  rsq_reset_event_sequencer rsq_reset_event_sequencer_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .extResetIn(extResetIn), .extResetOut(extResetOut), .extResetOe(extResetOe),
    .bootPinLo(bootPinLo), .bootPinHi(bootPinHi), .powerOnReq(powerOnReq),
    .powerOk(powerOk), .funcSrc(funcSrc), .destSrc(destSrc), .flashInitDone(flashInitDone),
    .flashOffRunMode(flashOffRunMode), .deepSleepReq(deepSleepReq),
    .deepSleepExit(deepSleepExit), .deepSleepAck(deepSleepAck), .phase(phase),
    .sysReset(sysReset), .flashReset(flashReset), .domainReset(domainReset),
    .bootMode(bootMode), .altReq(altReq));
  rsq_far_side rsq_far_side_i (.clk_sys(clk_sys), .extResetOe(extResetOe), .pullLow(pullLow),
    .bootVal(bootVal), .deepSleepAck(deepSleepAck), .extResetIn(extResetIn),
    .bootPinLo(bootPinLo), .bootPinHi(bootPinHi), .deepSleepExit(deepSleepExit));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    int t;
    @(posedge clk_sys);
    t = 0;
    awaddr <= 32'(a);
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && t < 40);
    bready <= 1'b0;
    chk("bvalid", 32'(bvalid), 32'h1);
    chk("bresp", 32'(bresp), 32'(er));
  endtask
  task automatic axr(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    int t;
    @(posedge clk_sys);
    t = 0;
    araddr <= 32'(a);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && t < 40);
    rready <= 1'b0;
    chk("rvalid", 32'(rvalid), 32'h1);
    chk("rdata", rdata, ed);
    chk("rresp", 32'(rresp), 32'(er));
  endtask
  task automatic wait_ph(rsq_pkg::rsq_phase_t p, int lim);
    int t;
    t = 0;
    while (phase !== p && t < lim) begin
      @(posedge clk_sys);
      t++;
    end
    chk("phase", 32'(phase), 32'(p));
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    end_sim();
  end
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, pullLow} <= 7'h00;
    {awaddr, wdata, araddr, wstrb, destSrc, funcSrc} <= '0;
    {powerOnReq, powerOk, flashInitDone, flashOffRunMode, deepSleepReq} <= 5'h00;
    bootVal <= 2'h1;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (rows[i]) axr(rows[i].ofs, rows[i].data, rows[i].resp);
    axw(8'h24, 32'h1, 2'h2);
    powerOk <= 1'b1;
    flashInitDone <= 1'b1;
    wait_ph(rsq_pkg::PH_IDLE, 4000);
    repeat (8) @(posedge clk_sys);
    chk("oe", 32'(extResetOe), 32'h0);
    chk("boot", 32'(bootMode), 32'h1);
    bootVal <= 2'h2;
    repeat (60) @(posedge clk_sys);
    pullLow <= 1'b1;
    wait_ph(rsq_pkg::PH_ONE, 10);
    pullLow <= 1'b0;
    axr(rsq_pkg::OFS_FUNC_STATUS, 32'h1, 2'h0);
    chk("oe", 32'(extResetOe), 32'h1);
    chk("pin", 32'(extResetOut), 32'h0);
    wait_ph(rsq_pkg::PH_IDLE, 4000);
    repeat (8) @(posedge clk_sys);
    chk("boot", 32'(bootMode), 32'h2);
    axw(rsq_pkg::OFS_FUNC_STATUS, 32'h1, 2'h0);
    axw(rsq_pkg::OFS_FUNC_SHORT, 32'h5, 2'h0);
    bootVal <= 2'h3;
    repeat (60) @(posedge clk_sys);
    pullLow <= 1'b1;
    wait_ph(rsq_pkg::PH_THREE, 10);
    chk("flash", 32'(flashReset), 32'h0);
    pullLow <= 1'b0;
    wait_ph(rsq_pkg::PH_IDLE, 1000);
    repeat (8) @(posedge clk_sys);
    chk("boot", 32'(bootMode), 32'h3);
    axw(rsq_pkg::OFS_FUNC_BIDIR, 32'hA, 2'h0);
    bootVal <= 2'h0;
    funcSrc <= 7'h05;
    wait_ph(rsq_pkg::PH_ONE, 10);
    chk("flash", 32'(flashReset), 32'h1);
    chk("oe", 32'(extResetOe), 32'h0);
    axr(rsq_pkg::OFS_FUNC_STATUS, 32'hB, 2'h0);
    funcSrc <= 7'h00;
    wait_ph(rsq_pkg::PH_IDLE, 4000);
    chk("boot", 32'(bootMode), 32'h3);
    axw(rsq_pkg::OFS_FUNC_STATUS, 32'hF, 2'h0);
    funcSrc <= 7'h02;
    wait_ph(rsq_pkg::PH_THREE, 10);
    funcSrc <= 7'h00;
    wait_ph(rsq_pkg::PH_IDLE, 1000);
    repeat (8) @(posedge clk_sys);
    chk("boot", 32'(bootMode), 32'h0);
    axw(rsq_pkg::OFS_FUNC_DISABLE, 32'h30, 2'h0);
    axw(rsq_pkg::OFS_FUNC_DISABLE, 32'h0, 2'h0);
    axr(rsq_pkg::OFS_FUNC_DISABLE, 32'h30, 2'h0);
    axw(rsq_pkg::OFS_FUNC_ALT, 32'h10, 2'h0);
    funcSrc <= 7'h08;
    repeat (4) @(posedge clk_sys);
    chk("alt", 32'(altReq), 32'h1);
    chk("phase", 32'(phase), 32'(rsq_pkg::PH_IDLE));
    funcSrc <= 7'h18;
    repeat (4) @(posedge clk_sys);
    funcSrc <= 7'h00;
    repeat (4) @(posedge clk_sys);
    chk("alt", 32'(altReq), 32'h3);
    axw(rsq_pkg::OFS_FUNC_STATUS, 32'h30, 2'h0);
    repeat (4) @(posedge clk_sys);
    chk("alt", 32'(altReq), 32'h0);
    deepSleepReq <= 1'b1;
    {flashOffRunMode, flashInitDone} <= 2'b10;
    wait_ph(rsq_pkg::PH_ONE, 10);
    deepSleepReq <= 1'b0;
    @(posedge clk_sys);
    chk("domain", 32'(domainReset), 32'h1);
    wait_ph(rsq_pkg::PH_IDLE, 4000);
    chk("flash", 32'(flashReset), 32'h1);
    {flashOffRunMode, flashInitDone} <= 2'b01;
    destSrc <= 2'h1;
    wait_ph(rsq_pkg::PH_ZERO, 5);
    destSrc <= 2'h0;
    chk("oe", 32'(extResetOe), 32'h1);
    wait_ph(rsq_pkg::PH_IDLE, 4000);
    powerOnReq <= 1'b1;
    wait_ph(rsq_pkg::PH_ZERO, 5);
    powerOnReq <= 1'b0;
    wait_ph(rsq_pkg::PH_IDLE, 4000);
    end_sim();
  end
endmodule
